// [verilog/pslc_pkg.sv]
// Purpose: shared constants and carriers for the status and indicator register bank
// Assumes: 16-bit management registers addressed by a 5-bit register number
// Notes: register numbers are the management-interface register addresses
package pslc_pkg;

  // ----------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] PSLC_ADDR_STATE = 5'h1A; // transceiver_state_report
  localparam logic [4:0] PSLC_ADDR_IND1 = 5'h1B; // indicator_control_one

  // ----------------------------------------------------------------
  // state report field positions
  // ----------------------------------------------------------------
  localparam int PSLC_ST_SWAP = 11;
  localparam int PSLC_ST_POL = 10;
  localparam int PSLC_ST_SPD_HI = 9;
  localparam int PSLC_ST_SPD_LO = 8;
  localparam int PSLC_ST_DUPLEX = 7;
  localparam int PSLC_ST_LINK = 6;
  localparam int PSLC_ST_TX = 5;
  localparam int PSLC_ST_RX = 4;
  localparam int PSLC_ST_COL = 3;
  localparam int PSLC_ST_ANEG = 2;
  localparam int PSLC_ST_PAUSE = 1;
  localparam int PSLC_ST_ASYM = 0;

  // ----------------------------------------------------------------
  // indicator control one field positions
  // ----------------------------------------------------------------
  localparam int PSLC_IC_TWO_FAST_TEN = 15;
  localparam int PSLC_IC_TWO_LA_GIG = 14;
  localparam int PSLC_IC_EXT_TEN = 13;
  localparam int PSLC_IC_EXT_FAST = 12;
  localparam int PSLC_IC_EXT_GIG = 11;
  localparam int PSLC_IC_EXT_LA = 10;
  localparam int PSLC_IC_PAUSE_HI = 7;
  localparam int PSLC_IC_PAUSE_LO = 4;
  localparam int PSLC_IC_STR_HI = 3;
  localparam int PSLC_IC_STR_LO = 2;
  localparam int PSLC_IC_OFF = 1;
  localparam int PSLC_IC_PSTR = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PSLC_SPD_UNKNOWN = 2'h3;
  localparam logic [1:0] PSLC_SPD_GIG = 2'h2;
  localparam logic [1:0] PSLC_SPD_FAST = 2'h1;
  localparam logic [1:0] PSLC_SPD_TEN = 2'h0;
  localparam logic PSLC_RST_POL = 1'h1;
  localparam logic [3:0] PSLC_RST_PAUSE = 4'h0;
  localparam logic [1:0] PSLC_RST_STR = 2'h0;
  localparam logic PSLC_RST_PSTR = 1'h1;
  // writable bits of indicator control one; 9:8 reserved
  localparam logic [15:0] PSLC_IC_WMASK = 16'hFCFF;

  // ----------------------------------------------------------------
  // stretch timing (20 MHz, 50 ns)
  // ----------------------------------------------------------------
  localparam int PSLC_CLK_KHZ = 20000;
  localparam int PSLC_STR0_MS = 32;
  localparam int PSLC_STR1_MS = 64;
  localparam int PSLC_STR2_MS = 104;
  localparam int PSLC_STR0_CYC = PSLC_STR0_MS * PSLC_CLK_KHZ;
  localparam int PSLC_STR1_CYC = PSLC_STR1_MS * PSLC_CLK_KHZ;
  localparam int PSLC_STR2_CYC = PSLC_STR2_MS * PSLC_CLK_KHZ;

  // ----------------------------------------------------------------
  // standard function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] PSLC_FN_GIG = 4'h0;
  localparam logic [3:0] PSLC_FN_FAST = 4'h1;
  localparam logic [3:0] PSLC_FN_TEN = 4'h2;
  localparam logic [3:0] PSLC_FN_GIG_FASTBL = 4'h3;
  localparam logic [3:0] PSLC_FN_LINK = 4'h4;
  localparam logic [3:0] PSLC_FN_TX = 4'h5;
  localparam logic [3:0] PSLC_FN_RX = 4'h6;
  localparam logic [3:0] PSLC_FN_ACT = 4'h7;
  localparam logic [3:0] PSLC_FN_FDX = 4'h8;
  localparam logic [3:0] PSLC_FN_COL = 4'h9;
  localparam logic [3:0] PSLC_FN_LINK_ACT = 4'hA;
  localparam logic [3:0] PSLC_FN_LINK_RX = 4'hB;
  localparam logic [3:0] PSLC_FN_LINK_COL = 4'hC;
  localparam logic [3:0] PSLC_FN_BLINK = 4'hD;
  localparam logic [3:0] PSLC_FN_ON = 4'hE;
  localparam logic [3:0] PSLC_FN_OFF = 4'hF;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // live line-side conditions feeding the state report
  typedef struct packed {
    logic pair_swap;
    logic pol_inv;
    logic [1:0] speed;
    logic full_duplex;
    logic link_up;
    logic tx_busy;
    logic rx_busy;
    logic collision;
    logic aneg_local;
    logic aneg_partner;
    logic lp_pause;
    logic lp_asym;
  } pslc_line_t;

  // four indicator function codes, ten/fast/gig/link-activity
  typedef struct packed {
    logic [3:0] ten;
    logic [3:0] fast;
    logic [3:0] gig;
    logic [3:0] link_act;
  } pslc_codes_t;

  // indicator levels, one bit per lamp, lit high
  typedef struct packed {
    logic ten;
    logic fast;
    logic gig;
    logic link_act;
  } pslc_lamps_t;

endpackage

// [verilog/pslc_regs.sv]
// Purpose: status report and indicator control one registers with indicator drive
// Assumes: the management frame engine presents one register access per strobe
// Notes: all line-side conditions arrive synchronous to clk_sys_i
//
// What this block does
// - bit 11 reports pairs A/B swapped
// - bit 10 polarity inverted at 10M, resets one
// - bits 9:8 speed code, resets undetermined
// - bit 7 full duplex, resets zero
// - bit 6 link up, resets zero
// - bit 5 transmitting a packet
// - bit 4 receiving a packet
// - bit 3 live collision indication
// - bit 2 both ends auto-negotiate
// - bits 1,0 partner pause and asymmetric pause
// - bit 14 two-colour link-activity with gigabit
// - bit 15 two-colour fast with ten
// - two-colour pair never lights both lamps
// - bits 13:10 extended or standard decoding
// - ten-extended bit loaded from strap
// - bits 7:4 blink pause count, resets zero
// - bits 3:2 stretch 32/64/104 ms
// - bit 1 forces lamps off, strap reset
// - standard function codes select displayed condition
`timescale 1ns/10ps
module pslc_regs
  import pslc_pkg::*;
#(
  parameter int STR0_CYC = PSLC_STR0_CYC, // 32 ms stretch in cycles
  parameter int STR1_CYC = PSLC_STR1_CYC, // 64 ms stretch in cycles
  parameter int STR2_CYC = PSLC_STR2_CYC, // 104 ms stretch in cycles
  parameter int BLINK_CYC = 2000000 // blink half-period in cycles
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic reg_req_i, // one-cycle access strobe
  input wire logic reg_wr_i, // 1 write, 0 read
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire pslc_line_t line_i,
  input wire pslc_codes_t codes_i,
  input wire logic indicator_config_strap_i,
  output pslc_lamps_t lamps_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] state_report; // sampled line state
  logic [15:0] ind_ctl; // indicator control one
  logic strap_pend; // strap still to be captured after reset
  logic [31:0] str_cnt; // stretch hold counter
  logic [31:0] blink_cnt; // blink half-period counter
  logic [3:0] pause_cnt; // remaining pause half-periods of the blink pattern
  logic blink; // blink phase
  pslc_lamps_t raw; // decoded lamp functions
  pslc_lamps_t shown; // after pairing and disable
  logic evt; // any tx/rx/col event
  logic stretched; // stretched event level
  logic [31:0] str_len; // selected stretch length

  // standard or extended decode of one function code
  function automatic logic decode(input logic [3:0] code, input logic ext,
                                  input logic [15:0] st, input logic act, input logic bl);
    logic r;
    logic lk;
    logic [1:0] sp;
    r = 1'b0;
    lk = st[PSLC_ST_LINK];
    sp = st[PSLC_ST_SPD_HI:PSLC_ST_SPD_LO];
    if (!ext) begin
      case (code)
        PSLC_FN_GIG: r = lk && sp == PSLC_SPD_GIG;
        PSLC_FN_FAST: r = lk && sp == PSLC_SPD_FAST;
        PSLC_FN_TEN: r = lk && sp == PSLC_SPD_TEN;
        PSLC_FN_GIG_FASTBL: r = lk && (sp == PSLC_SPD_GIG || (sp == PSLC_SPD_FAST && bl));
        PSLC_FN_LINK: r = lk;
        PSLC_FN_TX: r = st[PSLC_ST_TX];
        PSLC_FN_RX: r = st[PSLC_ST_RX];
        PSLC_FN_ACT: r = act;
        PSLC_FN_FDX: r = st[PSLC_ST_DUPLEX];
        PSLC_FN_COL: r = st[PSLC_ST_COL];
        PSLC_FN_LINK_ACT: r = lk && !(act && bl);
        PSLC_FN_LINK_RX: r = lk && !(st[PSLC_ST_RX] && bl);
        PSLC_FN_LINK_COL: r = lk && !(st[PSLC_ST_COL] && bl);
        PSLC_FN_BLINK: r = bl;
        PSLC_FN_ON: r = 1'b1;
        PSLC_FN_OFF: r = 1'b0;
        default: r = 1'b0;
      endcase
    end else begin
      // extended set: single speeds or speed pairs, optionally with activity blink
      case (code)
        4'h0: r = lk && (sp == PSLC_SPD_TEN || sp == PSLC_SPD_FAST);
        4'h1: r = lk && (sp == PSLC_SPD_FAST || sp == PSLC_SPD_GIG);
        4'h2: r = lk && sp == PSLC_SPD_FAST && !(act && bl);
        4'h3: r = lk && sp == PSLC_SPD_TEN && !(act && bl);
        4'h4: r = lk && sp == PSLC_SPD_GIG && !(act && bl);
        4'h5: r = lk && sp != PSLC_SPD_GIG && !(act && bl);
        4'h6: r = lk && sp != PSLC_SPD_TEN && !(act && bl);
        4'h7: r = lk && (sp == PSLC_SPD_TEN || sp == PSLC_SPD_GIG);
        default: r = 1'b0; // unlisted extended codes keep the lamp dark
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state report sampling
  // ----------------------------------------------------------------
  // sampled each cycle so a read returns a stable, one-cycle-old view
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_report <= '0;
      state_report[PSLC_ST_POL] <= PSLC_RST_POL;
      state_report[PSLC_ST_SPD_HI:PSLC_ST_SPD_LO] <= PSLC_SPD_UNKNOWN;
    end else begin
      state_report <= '0; // bits 15:12 belong to other logic, shown zero here
      state_report[PSLC_ST_SWAP] <= line_i.pair_swap;
      // polarity only means something at 10 Mb/s; elsewhere show the reset value
      state_report[PSLC_ST_POL] <= (line_i.speed == PSLC_SPD_TEN) ?
                                   line_i.pol_inv : PSLC_RST_POL;
      state_report[PSLC_ST_SPD_HI:PSLC_ST_SPD_LO] <= line_i.speed;
      state_report[PSLC_ST_DUPLEX] <= line_i.full_duplex;
      state_report[PSLC_ST_LINK] <= line_i.link_up;
      state_report[PSLC_ST_TX] <= line_i.tx_busy;
      state_report[PSLC_ST_RX] <= line_i.rx_busy;
      state_report[PSLC_ST_COL] <= line_i.collision;
      state_report[PSLC_ST_ANEG] <= line_i.aneg_local && line_i.aneg_partner;
      state_report[PSLC_ST_PAUSE] <= line_i.lp_pause;
      state_report[PSLC_ST_ASYM] <= line_i.lp_asym;
    end
  end

  // ----------------------------------------------------------------
  // indicator control one
  // ----------------------------------------------------------------
  // strap is caught on the first clock after reset release, never under reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      strap_pend <= 1'b1;
    end else begin
      strap_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ind_ctl <= '0; // two-colour and extended bits off
      ind_ctl[PSLC_IC_PAUSE_HI:PSLC_IC_PAUSE_LO] <= PSLC_RST_PAUSE;
      ind_ctl[PSLC_IC_STR_HI:PSLC_IC_STR_LO] <= PSLC_RST_STR;
      ind_ctl[PSLC_IC_PSTR] <= PSLC_RST_PSTR;
    end else if (strap_pend) begin
      ind_ctl[PSLC_IC_EXT_TEN] <= indicator_config_strap_i;
      ind_ctl[PSLC_IC_OFF] <= indicator_config_strap_i;
    end else if (reg_req_i && reg_wr_i && reg_addr_i == PSLC_ADDR_IND1) begin
      ind_ctl <= reg_wdata_i & PSLC_IC_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped registers read zero; the status register ignores writes
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
      reg_ack_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_req_i;
      if (reg_req_i && !reg_wr_i) begin
        case (reg_addr_i)
          PSLC_ADDR_STATE: reg_rdata_o <= state_report;
          PSLC_ADDR_IND1: reg_rdata_o <= ind_ctl;
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // event stretching
  // ----------------------------------------------------------------
  always_comb begin
    case (ind_ctl[PSLC_IC_STR_HI:PSLC_IC_STR_LO])
      2'h0: str_len = 32'(STR0_CYC);
      2'h1: str_len = 32'(STR1_CYC);
      2'h2: str_len = 32'(STR2_CYC);
      default: str_len = 32'(STR0_CYC); // reserved code falls back to shortest
    endcase
  end

  assign evt = state_report[PSLC_ST_TX] | state_report[PSLC_ST_RX] | state_report[PSLC_ST_COL];

  // holds activity visible long enough for the eye to catch short packets
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      str_cnt <= '0;
    end else if (evt) begin
      str_cnt <= str_len;
    end else if (str_cnt != 32'h0) begin
      str_cnt <= str_cnt - 32'h1;
    end
  end

  assign stretched = evt | (ind_ctl[PSLC_IC_PSTR] && str_cnt != 32'h0);

  // ----------------------------------------------------------------
  // blink pattern with pause cycles
  // ----------------------------------------------------------------
  // after each on/off pair the lamp rests dark for the programmed pause count
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      blink_cnt <= '0;
      blink <= 1'b0;
      pause_cnt <= '0;
    end else if (blink_cnt != 32'(BLINK_CYC - 1)) begin
      blink_cnt <= blink_cnt + 32'h1;
    end else begin
      blink_cnt <= '0;
      if (pause_cnt != 4'h0) begin
        pause_cnt <= pause_cnt - 4'h1;
      end else if (blink) begin
        blink <= 1'b0;
        pause_cnt <= ind_ctl[PSLC_IC_PAUSE_HI:PSLC_IC_PAUSE_LO];
      end else begin
        blink <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // lamp decode, pairing and output
  // ----------------------------------------------------------------
  always_comb begin
    raw.ten = decode(codes_i.ten, ind_ctl[PSLC_IC_EXT_TEN], state_report,
                     stretched, blink);
    raw.fast = decode(codes_i.fast, ind_ctl[PSLC_IC_EXT_FAST], state_report,
                      stretched, blink);
    raw.gig = decode(codes_i.gig, ind_ctl[PSLC_IC_EXT_GIG], state_report,
                     stretched, blink);
    raw.link_act = decode(codes_i.link_act, ind_ctl[PSLC_IC_EXT_LA], state_report,
                          stretched, blink);
    shown = raw;
    // two-colour: first lamp is the pair's and, second lamp lit only alone
    if (ind_ctl[PSLC_IC_TWO_LA_GIG]) begin
      shown.link_act = raw.link_act & raw.gig;
      shown.gig = raw.gig & ~raw.link_act;
    end
    if (ind_ctl[PSLC_IC_TWO_FAST_TEN]) begin
      shown.fast = raw.fast & raw.ten;
      shown.ten = raw.ten & ~raw.fast;
    end
    if (ind_ctl[PSLC_IC_OFF]) begin
      shown = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lamps_o <= '0;
    end else begin
      lamps_o <= shown;
    end
  end

endmodule

// [tb/pslc_regs_chk.sv]
// Purpose: port checker for the status and indicator register bank
// Assumes: status reads are judged only while line_i holds still
// Notes: bound to pslc_regs at the foot of this file
`timescale 1ns/10ps
module pslc_regs_chk
  import pslc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic reg_req_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire pslc_line_t line_i,
  input wire pslc_lamps_t lamps_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [1:0] since_rst; // edges since reset, saturating
  logic [1:0] two_pair; // shadow of two-colour bits 15:14
  // the first edge after reset captures the strap and drops a write, though a request there is still answered
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      since_rst <= 2'h0;
    end else if (since_rst != 2'h3) begin
      since_rst <= since_rst + 2'h1;
    end
  end
  // shadow follows taken writes only
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      two_pair <= 2'h0;
    end else if (reg_req_i && reg_wr_i && reg_addr_i == PSLC_ADDR_IND1 && since_rst != 2'h0) begin
      two_pair <= reg_wdata_i[15:14];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence taken_s;
    reg_req_i && since_rst != 2'h0;
  endsequence
  // steady line covers the one-clock lag of the report
  sequence st_read_s;
    taken_s ##0 (!reg_wr_i && reg_addr_i == PSLC_ADDR_STATE && since_rst == 2'h3 && $stable(line_i));
  endsequence
  ack_follows_req_a: assert property (taken_s |=> reg_ack_o)
    else $error("answer missing after request");
  ack_needs_req_a: assert property (!reg_req_i |=> !reg_ack_o)
    else $error("answer without request");
  swap_report_a: assert property (st_read_s |=> reg_rdata_o[11] == $past(line_i.pair_swap))
    else $error("pair swap bit wrong");
  polarity_report_a: assert property (st_read_s |=> reg_rdata_o[10] ==
    ($past(line_i.speed) == PSLC_SPD_TEN ? $past(line_i.pol_inv) : 1'b1))
    else $error("polarity bit wrong");
  speed_report_a: assert property (st_read_s |=> reg_rdata_o[9:8] == $past(line_i.speed))
    else $error("speed field wrong");
  duplex_link_a: assert property (st_read_s |=> reg_rdata_o[7:6] ==
    {$past(line_i.full_duplex), $past(line_i.link_up)})
    else $error("duplex or link bit wrong");
  activity_report_a: assert property (st_read_s |=> reg_rdata_o[5:3] ==
    {$past(line_i.tx_busy), $past(line_i.rx_busy), $past(line_i.collision)})
    else $error("activity bits wrong");
  aneg_both_a: assert property (st_read_s |=> reg_rdata_o[2] ==
    ($past(line_i.aneg_local) && $past(line_i.aneg_partner)))
    else $error("auto-negotiation bit wrong");
  pause_report_a: assert property (st_read_s |=> reg_rdata_o[1:0] ==
    {$past(line_i.lp_pause), $past(line_i.lp_asym)})
    else $error("pause bits wrong");
  reserved_zero_a: assert property (taken_s ##0 (!reg_wr_i && reg_addr_i == PSLC_ADDR_IND1) |=>
    reg_rdata_o[9:8] == 2'h0)
    else $error("reserved bits read nonzero");
  la_gig_excl_a: assert property (two_pair[0] && $past(two_pair[0]) && $past(two_pair[0], 2) |->
    !(lamps_o.link_act && lamps_o.gig))
    else $error("link-activity and gigabit both lit");
  fast_ten_excl_a: assert property (two_pair[1] && $past(two_pair[1]) && $past(two_pair[1], 2) |->
    !(lamps_o.fast && lamps_o.ten))
    else $error("fast and ten both lit");
endmodule
bind pslc_regs pslc_regs_chk u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_ack_o(reg_ack_o), .line_i(line_i), .lamps_o(lamps_o));

// [tb/pslc_mgmt_model.sv]
// Purpose: management controller model issuing one register access per command
// Assumes: strobe high one cycle, answer awaited before the next command
// Notes: outside the strobe, address and data show their inverse, never a stale copy
`timescale 1ns/10ps
module pslc_mgmt_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic go_i, // one-cycle command from the bench
  input wire logic wr_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic done_o, // one-cycle, rdata_o valid
  output logic [15:0] rdata_o,
  output logic reg_req_o,
  output logic reg_wr_o,
  output logic [4:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic reg_ack_i,
  input wire logic [15:0] reg_rdata_i
);
  logic busy; // waiting for the answer
  logic [4:0] ad; // held address
  logic [15:0] wd; // held write word
  assign reg_addr_o = reg_req_o ? ad : ~ad;
  assign reg_wdata_o = reg_req_o ? wd : ~wd;
  // strobe once, then take the answer at the edge where ack is seen
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_req_o <= 1'b0;
      busy <= 1'b0;
      done_o <= 1'b0;
    end else begin
      reg_req_o <= go_i && !busy;
      done_o <= busy && reg_ack_i;
      if (go_i && !busy) begin
        busy <= 1'b1;
        reg_wr_o <= wr_i;
        ad <= addr_i;
        wd <= wdata_i;
      end else if (busy && reg_ack_i) begin
        busy <= 1'b0;
        rdata_o <= reg_rdata_i;
      end
    end
  end
endmodule

// [tb/tb_phy_status_led_config_regs.sv]
// Purpose: self-checking bench for the status and indicator register bank
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes: random line levels and control words from a fixed seed
`timescale 1ns/10ps
module tb_phy_status_led_config_regs
  import pslc_pkg::*;
;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0] code;
    logic link;
    logic [3:0] lamps;
  } pslc_lamp_case_t;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic go = 1'b0; // command to the model
  logic wr_c = 1'b0;
  logic [4:0] addr_c = 5'h00;
  logic [15:0] wd_c = 16'h0000;
  logic done;
  logic [15:0] rd; // last answer seen by the model
  logic req, wr, ack;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, w;
  pslc_line_t line = '0;
  pslc_line_t ln;
  pslc_codes_t codes = '0;
  logic strap = 1'b0;
  pslc_lamps_t lamps;
  int num_errors = 0;
  int n_checks = 0;
  int seed = 74;
  int cycles = 0;
  // short stretch and blink lengths keep the run brief; 8/16/26 keeps the 32/64/104 ratio
  localparam int STR0_TB = 8;
  localparam int STR1_TB = 16;
  localparam int STR2_TB = 26;
  localparam int BLINK_TB = 4;
  int t0, t1, nr; // blink rise times and rise count
  logic lt; // lamp level at the previous sample
  logic [3:0] pv; // programmed blink pause count
  // table order: ctrl, code, link, {ten,fast,gig,link_act}
  pslc_lamp_case_t lamp_cases [14] = '{
    {16'h0000, 4'hE, 1'b0, 4'hF}, {16'h0002, 4'hE, 1'b0, 4'h0}, {16'hC000, 4'hE, 1'b0, 4'h5},
    {16'h8000, 4'hE, 1'b0, 4'h7}, {16'h4000, 4'hE, 1'b0, 4'hD}, {16'h3C00, 4'hE, 1'b0, 4'h0},
    {16'h0000, 4'hF, 1'b0, 4'h0}, {16'h0000, 4'h4, 1'b1, 4'hF}, {16'h0000, 4'h4, 1'b0, 4'h0},
    {16'h0000, 4'h2, 1'b1, 4'hF}, {16'h0000, 4'h0, 1'b1, 4'h0}, {16'h3C00, 4'h0, 1'b1, 4'hF},
    {16'h3C00, 4'h4, 1'b1, 4'h0}, {16'h2000, 4'h4, 1'b1, 4'h7}};
  pslc_regs #(.STR0_CYC(STR0_TB), .STR1_CYC(STR1_TB), .STR2_CYC(STR2_TB),
    .BLINK_CYC(BLINK_TB)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .line_i(line),
    .codes_i(codes), .indicator_config_strap_i(strap), .lamps_o(lamps));
  pslc_mgmt_model u_mgmt (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .go_i(go), .wr_i(wr_c),
    .addr_i(addr_c), .wdata_i(wd_c), .done_o(done), .rdata_o(rd), .reg_req_o(req), .reg_wr_o(wr),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_ack_i(ack), .reg_rdata_i(rdata));
  // expected report word built from the line levels
  function automatic logic [15:0] exp_state(input pslc_line_t l);
    exp_state = {4'h0, l.pair_swap, (l.speed == PSLC_SPD_TEN) ? l.pol_inv : 1'b1, l.speed,
      l.full_duplex, l.link_up, l.tx_busy, l.rx_busy, l.collision,
      l.aneg_local & l.aneg_partner, l.lp_pause, l.lp_asym};
  endfunction
  // stretch length each select should give; 4 stands for stretching switched off
  function automatic int exp_str(input int s);
    exp_str = (s == 4) ? 0 : (s == 1) ? STR1_TB : (s == 2) ? STR2_TB : STR0_TB;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one access through the model; waits a bounded time for its answer
  task automatic acc(input logic wv, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    go <= 1'b1;
    wr_c <= wv;
    addr_c <= a;
    wd_c <= d;
    @(posedge clk_sys_i);
    go <= 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check("answer", {15'h0, done}, 16'h0001);
  endtask
  task automatic do_reset(input logic s);
    strap <= s;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  always #25 clk_sys_i = ~clk_sys_i;
  // hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    do_reset(1'b0);
    acc(1'b0, PSLC_ADDR_IND1, 16'h0000);
    check("ctrl reset", rd, 16'h0001);
    foreach (lamp_cases[k]) begin
      @(posedge clk_sys_i);
      ln = '0;
      ln.link_up = lamp_cases[k].link;
      line <= ln;
      codes <= {4{lamp_cases[k].code}};
      acc(1'b1, PSLC_ADDR_IND1, lamp_cases[k].ctrl);
      repeat (4) @(posedge clk_sys_i);
      #1;
      check("lamps", {12'h000, lamps}, {12'h000, lamp_cases[k].lamps});
    end
    for (int i = 0; i < 20; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($random(seed));
      acc(1'b1, PSLC_ADDR_IND1, w);
      acc(1'b0, PSLC_ADDR_IND1, 16'h0000);
      check("ctrl readback", rd, w & PSLC_IC_WMASK);
    end
    // corners first: every line level low, then every one high
    for (int i = 0; i < 32; i++) begin
      ln = (i < 2) ? {13{i[0]}} : 13'($random(seed));
      @(posedge clk_sys_i);
      line <= ln;
      repeat (2) @(posedge clk_sys_i);
      if (i == 5) acc(1'b1, PSLC_ADDR_STATE, 16'hFFFF);
      acc(1'b0, PSLC_ADDR_STATE, 16'h0000);
      check("state report", rd, exp_state(ln));
    end
    acc(1'b0, 5'h05, 16'h0000);
    check("unmapped read", rd, 16'h0000);
    // stretch: one-cycle transmit pulse, lamp held for the selected length
    codes <= {4{PSLC_FN_ACT}};
    for (int s = 0; s < 5; s++) begin
      line <= '0;
      acc(1'b1, PSLC_ADDR_IND1, (s == 4) ? 16'h0000 : {12'h000, 2'(s), 2'h1});
      repeat (30) @(posedge clk_sys_i);
      ln = '0;
      ln.tx_busy = 1'b1;
      line <= ln;
      @(posedge clk_sys_i);
      line <= '0;
      repeat (exp_str(s) + 1) @(posedge clk_sys_i);
      #1;
      check("stretch lit", {12'h000, lamps}, 16'h000F);
      @(posedge clk_sys_i);
      #1;
      check("stretch end", {12'h000, lamps}, 16'h0000);
    end
    // blink: rise to rise spans on, off and the pause count, in half-periods
    codes <= {4{PSLC_FN_BLINK}};
    for (int k = 0; k < 3; k++) begin
      pv = (k == 2) ? 4'hF : 4'(3 * k);
      acc(1'b1, PSLC_ADDR_IND1, {8'h00, pv, 4'h0});
      t0 = 0;
      t1 = 0;
      nr = 0;
      lt = 1'b1;
      for (int c = 0; c < 300 && nr < 3; c++) begin
        @(posedge clk_sys_i);
        #1;
        if (lamps.ten && !lt) begin
          nr++;
          t0 = t1;
          t1 = c;
        end
        lt = lamps.ten;
      end
      check("blink period", 16'(t1 - t0), 16'((2 + pv) * BLINK_TB));
    end
    codes <= {4{PSLC_FN_ON}};
    do_reset(1'b1);
    acc(1'b0, PSLC_ADDR_IND1, 16'h0000);
    check("ctrl strap reset", rd, 16'h2003);
    repeat (4) @(posedge clk_sys_i);
    #1;
    check("lamps strap off", {12'h000, lamps}, 16'h0000);
    test_done();
  end
endmodule
